// file: rtl/ddrbp_pkg.sv
// Purpose: Shared constants and state types of the two-word burst memory port.
// Assumes: Default organisation is 1M words of 18 bits, addressed as burst pairs.
// Notes: Set DATA_W to 36 and ADDR_W to 18 for the 512K x 36 organisation.
package ddrbp_pkg;
  localparam int DATA_W = 18;
  localparam int ADDR_W = 19;
  localparam int CNT_W = 16;
  localparam int IR_W = 3;
  localparam logic [IR_W-1:0] IR_IDCODE = 3'h0;
  localparam logic [IR_W-1:0] IR_BYPASS = 3'h7;
  localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1;
  localparam logic [31:0] IDCODE_RESET = 32'h0000_0001;
  localparam logic [DATA_W-1:0] WORD_ZERO = '0;

  typedef enum logic [3:0] {
    TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h2, TAP_CAP_DR = 4'h3,
    TAP_SH_DR = 4'h4, TAP_EX1_DR = 4'h5, TAP_PA_DR = 4'h6, TAP_EX2_DR = 4'h7,
    TAP_UP_DR = 4'h8, TAP_SEL_IR = 4'h9, TAP_CAP_IR = 4'ha, TAP_SH_IR = 4'hb,
    TAP_EX1_IR = 4'hc, TAP_PA_IR = 4'hd, TAP_EX2_IR = 4'he, TAP_UP_IR = 4'hf
  } ddrbp_tap_state_type;

  typedef struct packed {
    ddrbp_tap_state_type state;
    logic [IR_W-1:0] ir;
    logic [IR_W-1:0] ir_sh;
    logic [31:0] dr;
  } ddrbp_tap_type;

  // Link (true clock) domain state.
  typedef struct packed {
    logic [1:0] lat_sync;
    logic busy;
    logic wr_data;
    logic [ADDR_W-1:0] wr_addr;
    logic wr_commit;
    logic [ADDR_W-1:0] cm_addr;
    logic [DATA_W-1:0] wd0;
    logic rd1;
    logic [ADDR_W-1:0] rd_addr;
    logic rd2;
    logic [DATA_W-1:0] w0;
    logic [DATA_W-1:0] w1;
    logic kpend;
    logic kn_go;
    logic [DATA_W-1:0] kn_word;
    logic [DATA_W-1:0] q;
    logic v;
    logic wr_tog;
  } ddrbp_k_type;

  // Complement clock domain state.
  typedef struct packed {
    logic [DATA_W-1:0] d1;
    logic [DATA_W-1:0] q;
    logic v;
  } ddrbp_kn_type;

  // Core clock domain state.
  typedef struct packed {
    logic [2:0] tog_sync;
    logic done;
    logic [CNT_W-1:0] count;
  } ddrbp_core_type;
endpackage

// file: rtl/ddrbp_port.sv
// Purpose: Two-word burst double-data-rate static memory port with storage array.
// Assumes: K_CLK and K_CLK_N are the complementary input clocks of the link.
// Notes: Each output half-word is the XOR of one flop per clock, so it is launched by one edge.
`timescale 1ns/100ps
// Operation
// - An address is captured on a true-clock rising edge and the next edge ignores the address.
// - Write words are captured on the true-clock rise and then the complement-clock rise.
// - Read words are launched on rising edges of both input clocks.
// - Each address holds two consecutive words moved as one burst.
// - With the latency pin high the first read word appears 2.5 cycles after the address.
// - With the latency pin low the first read word appears one cycle after the address.
// - The valid flag is high exactly while read data is on the data pins.
// - Read data shares the write data pins and echo clocks track the output data.
// - All synchronous link inputs and outputs pass registers clocked by the input clock pair.
// - Only rising edges of the two input clocks do anything.
// - A captured write completes into the array without further controller timing.
// - Storage holds 1M words of 18 bits or 512K words of 36 bits.
// - A boundary-scan test access port is provided.
module ddrbp_port #(
  parameter logic [31:0] ID_VALUE = ddrbp_pkg::IDCODE_RESET
) (
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  input wire logic K_CLK,
  input wire logic K_CLK_N,
  input wire logic [ddrbp_pkg::ADDR_W-1:0] ADDR,
  input wire logic LOAD_N,
  input wire logic READ_WRITE,
  input wire logic [ddrbp_pkg::DATA_W-1:0] DQ_IN,
  output logic [ddrbp_pkg::DATA_W-1:0] DQ_OUT,
  output logic DQ_OE,
  output logic READ_VALID_FLAG,
  output logic ECHO_CLOCK_OUT,
  output logic ECHO_CLOCK_OUT_N,
  input wire logic LATENCY_SELECT_PIN,
  output logic WRITE_DONE,
  output logic [ddrbp_pkg::CNT_W-1:0] WRITE_COUNT,
  input wire logic TCK,
  input wire logic TMS,
  input wire logic TDI,
  output logic TDO,
  output logic TDO_OE
);
  localparam int MEM_WORDS = 2 ** (ddrbp_pkg::ADDR_W + 1);

  ddrbp_pkg::ddrbp_k_type k_reg, k_next;
  ddrbp_pkg::ddrbp_kn_type kn_reg, kn_next;
  ddrbp_pkg::ddrbp_core_type c_reg, c_next;
  logic [ddrbp_pkg::DATA_W-1:0] mem [0:MEM_WORDS-1];
  logic take;
  logic take_read;
  logic take_write;
  logic slow;
  logic [ddrbp_pkg::DATA_W-1:0] rd_word0;
  logic [ddrbp_pkg::DATA_W-1:0] rd_word1;

  // ----------------------------------------------------------------
  // Address capture and read pipeline on the true clock
  // ----------------------------------------------------------------
  // An address is taken only when the previous edge took none.
  // A load held low over the following edge is dropped without any indication.
  assign take = !LOAD_N && !k_reg.busy;
  assign take_read = take && READ_WRITE;
  assign take_write = take && !READ_WRITE;
  assign slow = k_reg.lat_sync[1];
  assign rd_word0 = mem[{k_reg.rd_addr, 1'b0}];
  assign rd_word1 = mem[{k_reg.rd_addr, 1'b1}];

  always_comb begin
    logic launch;
    logic [ddrbp_pkg::DATA_W-1:0] word;
    launch = 1'b0;
    word = ddrbp_pkg::WORD_ZERO;
    k_next = k_reg;
    k_next.lat_sync = {k_reg.lat_sync[0], LATENCY_SELECT_PIN};
    k_next.busy = take;
    k_next.wr_data = take_write;
    k_next.rd1 = take_read;
    k_next.rd2 = 1'b0;
    k_next.kpend = 1'b0;
    k_next.kn_go = 1'b0;
    k_next.kn_word = ddrbp_pkg::WORD_ZERO;
    k_next.wr_commit = 1'b0;
    if (take) begin
      k_next.wr_addr = ADDR;
      if (READ_WRITE) begin
        k_next.rd_addr = ADDR;
      end
    end
    // First write word is taken on the true-clock edge after the address.
    if (k_reg.wr_data) begin
      k_next.wd0 = DQ_IN;
      k_next.cm_addr = k_reg.wr_addr;
      k_next.wr_commit = 1'b1;
    end
    if (k_reg.wr_commit) begin
      k_next.wr_tog = !k_reg.wr_tog;
    end
    if (k_reg.rd1) begin
      if (slow) begin
        k_next.rd2 = 1'b1;
        k_next.w0 = rd_word0;
        k_next.w1 = rd_word1;
      end else begin
        launch = 1'b1;
        word = rd_word0;
        k_next.kn_go = 1'b1;
        k_next.kn_word = rd_word1;
      end
    end
    if (k_reg.rd2) begin
      k_next.kn_go = 1'b1;
      k_next.kn_word = k_reg.w0;
      k_next.kpend = 1'b1;
    end
    if (k_reg.kpend) begin
      launch = 1'b1;
      word = k_reg.w1;
    end
    // The pins show the XOR of both output flops.
    // Loading word XOR the other flop makes the pins show the word just launched.
    // An idle edge launches zero, so the pins return to zero between bursts.
    k_next.q = word ^ kn_reg.q;
    k_next.v = launch ^ kn_reg.v;
  end

  always_ff @(posedge K_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      k_reg <= '0;
    end else begin
      k_reg <= k_next;
    end
  end

  // Self-timed array write of both burst words.
  always_ff @(posedge K_CLK) begin
    if (k_reg.wr_commit) begin
      mem[{k_reg.cm_addr, 1'b0}] <= k_reg.wd0;
      mem[{k_reg.cm_addr, 1'b1}] <= kn_reg.d1;
    end
  end

  // ----------------------------------------------------------------
  // Complement clock: second write word and mid-cycle read launch
  // ----------------------------------------------------------------
  always_comb begin
    kn_next = kn_reg;
    kn_next.d1 = DQ_IN;
    kn_next.q = k_reg.kn_word ^ k_reg.q;
    kn_next.v = k_reg.kn_go ^ k_reg.v;
  end

  always_ff @(posedge K_CLK_N or negedge ARST_N) begin
    if (!ARST_N) begin
      kn_reg <= '0;
    end else begin
      kn_reg <= kn_next;
    end
  end

  // ----------------------------------------------------------------
  // Shared data pins and echo clocks
  // ----------------------------------------------------------------
  assign DQ_OUT = k_reg.q ^ kn_reg.q;
  assign READ_VALID_FLAG = k_reg.v ^ kn_reg.v;
  assign DQ_OE = READ_VALID_FLAG;
  assign ECHO_CLOCK_OUT = K_CLK;
  assign ECHO_CLOCK_OUT_N = K_CLK_N;

  // ----------------------------------------------------------------
  // Write completion events into the core clock
  // ----------------------------------------------------------------
  always_comb begin
    c_next = c_reg;
    // Each completed write flips one bit in the link domain.
    // The flip crosses through two flops, and the third flop finds the edge.
    c_next.tog_sync = {c_reg.tog_sync[1:0], k_reg.wr_tog};
    c_next.done = c_reg.tog_sync[2] ^ c_reg.tog_sync[1];
    if (c_next.done) begin
      c_next.count = c_reg.count + 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      c_reg <= '0;
    end else begin
      c_reg <= c_next;
    end
  end

  assign WRITE_DONE = c_reg.done;
  assign WRITE_COUNT = c_reg.count;

  // ----------------------------------------------------------------
  // Test access port
  // ----------------------------------------------------------------
  ddrbp_tap #(
    .ID_VALUE(ID_VALUE)
  ) u_tap (
    .tck(TCK),
    .arst_n(ARST_N),
    .tms(TMS),
    .tdi(TDI),
    .tdo(TDO),
    .tdo_oe(TDO_OE)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_slow_pipe;
    k_reg.rd1 ##1 k_reg.rd2 ##1 (k_reg.kn_go && k_reg.kpend && READ_VALID_FLAG);
  endsequence

  sequence s_slow_first;
    k_reg.rd2 ##1 (k_reg.kn_go && k_reg.kpend);
  endsequence

  a_addr_alternate: assert property (@(posedge K_CLK) disable iff (!ARST_N)
    take |=> !take)
    else $error("Address captured on two consecutive true-clock edges.");

  a_write_commit: assert property (@(posedge K_CLK) disable iff (!ARST_N)
    take_write |-> ##1 k_reg.wr_data ##1 k_reg.wr_commit)
    else $error("Write did not commit two edges after its address.");

  a_write_pair: assert property (@(posedge K_CLK) disable iff (!ARST_N)
    k_reg.wr_commit |=> (mem[{$past(k_reg.cm_addr), 1'b0}] == $past(k_reg.wd0))
      && (mem[{$past(k_reg.cm_addr), 1'b1}] == $past(kn_reg.d1)))
    else $error("Burst write did not store both words.");

  a_fast_latency: assert property (@(posedge K_CLK) disable iff (!ARST_N)
    (take_read && !slow && $stable(slow)) |-> ##1 k_reg.rd1 ##1 (READ_VALID_FLAG && k_reg.kn_go))
    else $error("Short latency read not delivered one cycle after address.");

  a_slow_latency: assert property (@(posedge K_CLK) disable iff (!ARST_N)
    (take_read && slow && $stable(slow)) |-> ##1 s_slow_pipe)
    else $error("Long latency read not delivered 2.5 cycles after address.");

  a_half_launch: assert property (@(posedge K_CLK) disable iff (!ARST_N)
    k_reg.kn_go |-> (READ_VALID_FLAG && DQ_OUT == k_reg.kn_word))
    else $error("Complement-clock launch did not drive the queued word.");

  a_valid_cause: assert property (@(posedge K_CLK) disable iff (!ARST_N)
    READ_VALID_FLAG |-> ($past(k_reg.rd1) || $past(k_reg.rd2) || $past(k_reg.kpend)))
    else $error("Valid flag high without a read in flight.");

  a_burst_order: assert property (@(posedge K_CLK) disable iff (!ARST_N)
    s_slow_first |-> DQ_OUT == $past(k_reg.w0))
    else $error("First word of a long latency burst is not the even word.");

  a_done_count: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    c_reg.done |-> c_reg.count == $past(c_reg.count) + 1'b1)
    else $error("Write completion not counted.");

  // ----------------------------------------------------------------
  // Refusal, idle pins, first write word, second-word and single-pulse checks
  // ----------------------------------------------------------------
  sequence s_fast_pair;
    (k_reg.rd1 && !slow) ##1 READ_VALID_FLAG;
  endsequence

  a_load_refused: assert property (@(posedge K_CLK) disable iff (!ARST_N)
    (!LOAD_N && k_reg.busy) |=> (!k_reg.rd1 && !k_reg.wr_data))
    else $error("Address taken on the edge right after a capture.");

  a_idle_pins: assert property (@(posedge K_CLK) disable iff (!ARST_N)
    !READ_VALID_FLAG |-> DQ_OUT == ddrbp_pkg::WORD_ZERO)
    else $error("Data pins not zero while no read data is valid.");

  a_write_word0: assert property (@(posedge K_CLK) disable iff (!ARST_N)
    k_reg.wr_data |=> k_reg.wd0 == $past(DQ_IN))
    else $error("First write word not taken on the true-clock edge.");

  a_fast_second: assert property (@(posedge K_CLK) disable iff (!ARST_N)
    s_fast_pair |-> DQ_OUT == $past(rd_word1))
    else $error("Second word of a short latency burst is not the odd word.");

  // Sampled on the complement clock, since the second slow word stands between its edges.
  a_slow_second: assert property (@(posedge K_CLK_N) disable iff (!ARST_N)
    k_reg.kpend |=> DQ_OUT == $past(k_reg.w1))
    else $error("Second word of a long latency burst is not the odd word.");

  a_done_single: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    c_reg.done |=> !c_reg.done)
    else $error("Write completion pulse lasted more than one core cycle.");
endmodule

// file: rtl/ddrbp_tap.sv
// Purpose: Boundary-scan test access port with instruction, bypass and id registers.
// Assumes: TCK is a free clock of its own; TMS held high five edges resets the port.
// Notes: TDO is a mux of shift flops; unknown instructions select bypass.
`timescale 1ns/100ps
module ddrbp_tap #(
  parameter logic [31:0] ID_VALUE = ddrbp_pkg::IDCODE_RESET
) (
  input wire logic tck,
  input wire logic arst_n,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe
);
  ddrbp_pkg::ddrbp_tap_type st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    unique case (st_reg.state)
      ddrbp_pkg::TAP_RESET: st_next.state = tms ? ddrbp_pkg::TAP_RESET : ddrbp_pkg::TAP_IDLE;
      ddrbp_pkg::TAP_IDLE: st_next.state = tms ? ddrbp_pkg::TAP_SEL_DR : ddrbp_pkg::TAP_IDLE;
      ddrbp_pkg::TAP_SEL_DR: st_next.state = tms ? ddrbp_pkg::TAP_SEL_IR : ddrbp_pkg::TAP_CAP_DR;
      ddrbp_pkg::TAP_CAP_DR: st_next.state = tms ? ddrbp_pkg::TAP_EX1_DR : ddrbp_pkg::TAP_SH_DR;
      ddrbp_pkg::TAP_SH_DR: st_next.state = tms ? ddrbp_pkg::TAP_EX1_DR : ddrbp_pkg::TAP_SH_DR;
      ddrbp_pkg::TAP_EX1_DR: st_next.state = tms ? ddrbp_pkg::TAP_UP_DR : ddrbp_pkg::TAP_PA_DR;
      ddrbp_pkg::TAP_PA_DR: st_next.state = tms ? ddrbp_pkg::TAP_EX2_DR : ddrbp_pkg::TAP_PA_DR;
      ddrbp_pkg::TAP_EX2_DR: st_next.state = tms ? ddrbp_pkg::TAP_UP_DR : ddrbp_pkg::TAP_SH_DR;
      ddrbp_pkg::TAP_UP_DR: st_next.state = tms ? ddrbp_pkg::TAP_SEL_DR : ddrbp_pkg::TAP_IDLE;
      ddrbp_pkg::TAP_SEL_IR: st_next.state = tms ? ddrbp_pkg::TAP_RESET : ddrbp_pkg::TAP_CAP_IR;
      ddrbp_pkg::TAP_CAP_IR: st_next.state = tms ? ddrbp_pkg::TAP_EX1_IR : ddrbp_pkg::TAP_SH_IR;
      ddrbp_pkg::TAP_SH_IR: st_next.state = tms ? ddrbp_pkg::TAP_EX1_IR : ddrbp_pkg::TAP_SH_IR;
      ddrbp_pkg::TAP_EX1_IR: st_next.state = tms ? ddrbp_pkg::TAP_UP_IR : ddrbp_pkg::TAP_PA_IR;
      ddrbp_pkg::TAP_PA_IR: st_next.state = tms ? ddrbp_pkg::TAP_EX2_IR : ddrbp_pkg::TAP_PA_IR;
      ddrbp_pkg::TAP_EX2_IR: st_next.state = tms ? ddrbp_pkg::TAP_UP_IR : ddrbp_pkg::TAP_SH_IR;
      ddrbp_pkg::TAP_UP_IR: st_next.state = tms ? ddrbp_pkg::TAP_SEL_DR : ddrbp_pkg::TAP_IDLE;
    endcase
    unique case (st_reg.state)
      ddrbp_pkg::TAP_RESET: st_next.ir = ddrbp_pkg::IR_IDCODE;
      ddrbp_pkg::TAP_CAP_IR: st_next.ir_sh = ddrbp_pkg::IR_CAPTURE;
      ddrbp_pkg::TAP_SH_IR: st_next.ir_sh = {tdi, st_reg.ir_sh[ddrbp_pkg::IR_W-1:1]};
      ddrbp_pkg::TAP_UP_IR: st_next.ir = st_reg.ir_sh;
      ddrbp_pkg::TAP_CAP_DR: st_next.dr = (st_reg.ir == ddrbp_pkg::IR_IDCODE) ? ID_VALUE : '0;
      ddrbp_pkg::TAP_SH_DR: begin
        if (st_reg.ir == ddrbp_pkg::IR_IDCODE) begin
          st_next.dr = {tdi, st_reg.dr[31:1]};
        end else begin
          st_next.dr = {31'h0000_0000, tdi};
        end
      end
      default: st_next.dr = st_reg.dr;
    endcase
  end

  always_ff @(posedge tck or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '{state: ddrbp_pkg::TAP_RESET, ir: ddrbp_pkg::IR_IDCODE, ir_sh: '0, dr: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign tdo = (st_reg.state == ddrbp_pkg::TAP_SH_IR) ? st_reg.ir_sh[0] : st_reg.dr[0];
  assign tdo_oe = (st_reg.state == ddrbp_pkg::TAP_SH_IR) || (st_reg.state == ddrbp_pkg::TAP_SH_DR);

  a_tap_reset_walk: assert property (@(posedge tck) disable iff (!arst_n)
    tms [*5] |=> st_reg.state == ddrbp_pkg::TAP_RESET)
    else $error("Five high TMS edges did not reset the test port.");
endmodule

// file: test/ddr_two_word_burst_sram_port_tb.sv
// Purpose: Self-checking bench for the two-word burst memory port.
// Assumes: Link clock 125 ns, core clock 10 ns, test clock 100 ns.
// Notes: The data wire is resolved from the port's output enable.
`timescale 1ns/100ps
module ddr_two_word_burst_sram_port_tb;
  localparam int DW = ddrbp_pkg::DATA_W;
  localparam int AW = ddrbp_pkg::ADDR_W;
  localparam logic [8:0] TMS_SEQ = 9'h05f;
  logic core_clk = 1'b0;
  logic k_clk = 1'b0;
  logic tck = 1'b0;
  logic arst_n = 1'b0;
  logic lat = 1'b0;
  logic tms = 1'b1;
  logic tdi = 1'b0;
  wire logic k_clk_n = ~k_clk;
  logic [AW-1:0] addr;
  logic load_n, rw, rvalid, oe, eck, eck_n, done, tdo, tdo_oe;
  logic [DW-1:0] dq_out, ctrl_dq;
  logic [ddrbp_pkg::CNT_W-1:0] wcount;
  wire logic [DW-1:0] dq_wire = oe ? dq_out : ctrl_dq;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int done_cnt = 0;
  always #5 core_clk = ~core_clk;
  always #50 tck = ~tck;
  initial begin
    #17.3;
    forever #62.5 k_clk = ~k_clk;
  end
  ddrbp_port i_ddrbp_port (
    .CORE_CLK(core_clk), .ARST_N(arst_n), .K_CLK(k_clk), .K_CLK_N(k_clk_n), .ADDR(addr),
    .LOAD_N(load_n), .READ_WRITE(rw), .DQ_IN(dq_wire), .DQ_OUT(dq_out), .DQ_OE(oe),
    .READ_VALID_FLAG(rvalid), .ECHO_CLOCK_OUT(eck), .ECHO_CLOCK_OUT_N(eck_n),
    .LATENCY_SELECT_PIN(lat), .WRITE_DONE(done), .WRITE_COUNT(wcount), .TCK(tck),
    .TMS(tms), .TDI(tdi), .TDO(tdo), .TDO_OE(tdo_oe)
  );
  ddrbp_ctrl_model i_ddrbp_ctrl_model (
    .k_clk(k_clk), .k_clk_n(k_clk_n), .echo_clk(eck), .echo_clk_n(eck_n), .dq_out(dq_wire),
    .read_valid(rvalid), .addr(addr), .load_n(load_n), .read_write(rw), .dq_in(ctrl_dq)
  );
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    if (errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (done === 1'b1) begin
      done_cnt <= done_cnt + 1;
    end
    if (cycles == 3000) begin
      errors = errors + 1;
      close_out();
    end
  end
  function automatic logic [DW-1:0] pat(input logic [AW-1:0] a, input logic i);
    return {a[DW-2:0], i} ^ 18'h2_aaaa;
  endfunction
  task automatic wr(input logic [AW-1:0] a);
    i_ddrbp_ctrl_model.write_burst(a, pat(a, 1'b0), pat(a, 1'b1));
  endtask
  task automatic rd(input logic [AW-1:0] a, input logic hold);
    i_ddrbp_ctrl_model.read_burst(a, hold);
  endtask
  // Pops one burst from the controller and compares words, order and latency.
  task automatic exp_burst(input logic [AW-1:0] a, input int off);
    check("first word", 32'(i_ddrbp_ctrl_model.word_q.pop_front()), 32'(pat(a, 1'b0)));
    check("first lat", i_ddrbp_ctrl_model.off_q.pop_front(), off);
    check("second word", 32'(i_ddrbp_ctrl_model.word_q.pop_front()), 32'(pat(a, 1'b1)));
    check("second lat", i_ddrbp_ctrl_model.off_q.pop_front(), off + 1);
  endtask
  task automatic chk_idle();
    check("valid idle", rvalid, 32'h0);
    check("data idle", 32'(dq_out), 32'h0);
    check("enable idle", oe, 32'h0);
  endtask
  task automatic s_tap();
    logic [31:0] id;
    for (int i = 0; i < 9; i++) begin
      @(posedge tck);
      tms <= TMS_SEQ[i];
    end
    @(posedge tck);
    for (int i = 0; i < 32; i++) begin
      @(negedge tck);
      #25;
      id[i] = tdo;
    end
    check("shift enable", tdo_oe, 32'h1);
    check("id code", id, ddrbp_pkg::IDCODE_RESET);
    @(posedge tck);
    tms <= 1'b1;
  endtask
  task automatic s_fast();
    wr('0);
    wr(19'h0_0005);
    wr('1);
    rd('0, 1'b0);
    wr(19'h0_0009);
    rd(19'h0_0005, 1'b0);
    rd('1, 1'b0);
    repeat (4) @(posedge k_clk);
    check("words", i_ddrbp_ctrl_model.word_q.size(), 32'h6);
    exp_burst('0, 2);
    exp_burst(19'h0_0005, 2);
    exp_burst('1, 2);
    chk_idle();
    repeat (4) @(posedge core_clk);
    check("write count", 32'(wcount), 32'h4);
    check("done pulses", done_cnt, 32'h4);
  endtask
  task automatic s_slow();
    lat <= 1'b1;
    repeat (3) @(posedge k_clk);
    rd(19'h0_0005, 1'b0);
    rd(19'h0_0009, 1'b0);
    repeat (6) @(posedge k_clk);
    check("words", i_ddrbp_ctrl_model.word_q.size(), 32'h4);
    exp_burst(19'h0_0005, 5);
    exp_burst(19'h0_0009, 5);
    chk_idle();
    lat <= 1'b0;
    repeat (3) @(posedge k_clk);
  endtask
  task automatic s_refused();
    rd(19'h0_0009, 1'b1);
    repeat (4) @(posedge k_clk);
    check("words", i_ddrbp_ctrl_model.word_q.size(), 32'h2);
    exp_burst(19'h0_0009, 2);
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    repeat (2) @(posedge k_clk);
    @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge k_clk);
    check("write count", 32'(wcount), 32'h0);
    chk_idle();
    s_tap();
    @(posedge k_clk);
    s_fast();
    s_slow();
    s_refused();
    close_out();
  end
endmodule

// file: test/ddrbp_ctrl_model.sv
// Purpose: Behavioural memory controller on the far side of the burst port.
// Assumes: Tasks are entered just after a K_CLK rise and end just after one.
// Notes: Read words are taken on the echo clocks and queued with their latency.
`timescale 1ns/100ps
module ddrbp_ctrl_model #(
  parameter realtime HALF_NS = 62.5
) (
  input wire logic k_clk,
  input wire logic k_clk_n,
  input wire logic echo_clk,
  input wire logic echo_clk_n,
  input wire logic [ddrbp_pkg::DATA_W-1:0] dq_out,
  input wire logic read_valid,
  output logic [ddrbp_pkg::ADDR_W-1:0] addr,
  output logic load_n,
  output logic read_write,
  output logic [ddrbp_pkg::DATA_W-1:0] dq_in
);
  realtime take_q[$];
  realtime cur_take;
  logic [ddrbp_pkg::DATA_W-1:0] word_q[$];
  int off_q[$];
  int word_cnt = 0;
  initial begin
    addr = '0;
    load_n = 1'b1;
    read_write = 1'b1;
    dq_in = '0;
  end
  // Each word is taken 20 ns after the echo-clock edge that starts its half cycle.
  task automatic grab(input realtime te);
    #20;
    if (read_valid === 1'b1) begin
      if (word_cnt % 2 == 0) begin
        cur_take = take_q.pop_front();
      end
      word_q.push_back(dq_out);
      off_q.push_back(int'((te - cur_take) / HALF_NS));
      word_cnt++;
    end
  endtask
  always @(posedge echo_clk) grab($realtime);
  always @(posedge echo_clk_n) grab($realtime);
  task automatic write_burst(input logic [ddrbp_pkg::ADDR_W-1:0] a,
                             input logic [ddrbp_pkg::DATA_W-1:0] w0,
                             input logic [ddrbp_pkg::DATA_W-1:0] w1);
    load_n <= 1'b0;
    read_write <= 1'b0;
    addr <= a;
    @(posedge k_clk);
    load_n <= 1'b1;
    addr <= ~a;
    dq_in <= w0;
    @(posedge k_clk);
    dq_in <= w1;
    @(posedge k_clk_n);
    dq_in <= ~w1;
    @(posedge k_clk);
  endtask
  // A set hold keeps the load low on the edge after the take, with another address.
  task automatic read_burst(input logic [ddrbp_pkg::ADDR_W-1:0] a, input logic hold);
    load_n <= 1'b0;
    read_write <= 1'b1;
    addr <= a;
    @(posedge k_clk);
    take_q.push_back($realtime);
    addr <= ~a;
    load_n <= ~hold;
    @(posedge k_clk);
    // Only a held load is raised here, so a following call may lower it in this step.
    if (hold) begin
      load_n <= 1'b1;
    end
  endtask
endmodule
